// ===== hw/trig_io_pkg.sv
// Purpose: constants and carriers for the trigger and front io block
// Assumes: 50 MHz single clock
// Notes: register offsets are byte addresses
package trig_io_pkg;
  localparam logic [15:0] OFS_COINC_MASK  = 16'h810C;
  localparam logic [15:0] OFS_IO_DATA     = 16'h8118;
  localparam logic [15:0] OFS_IO_CTRL     = 16'h811C;
  localparam logic [15:0] OFS_ACQ_CTRL    = 16'h8100;
  localparam logic [15:0] OFS_SW_TRIGGER  = 16'h8108;
  localparam logic [15:0] OFS_ALMOST_FULL = 16'h816C;
  localparam logic [15:0] OFS_GROUP_MODE  = 16'h81A0;
  localparam logic [15:0] OFS_TRIG_CTRL   = 16'h8120;
  localparam logic [15:0] OFS_STATUS      = 16'h8124;
  localparam int MASK_LSB      = 0;
  localparam int WIN_LSB       = 20;
  localparam int MAJ_LSB       = 24;
  localparam int DIR_LSB       = 2;
  localparam int NEWMODE_BIT   = 8;
  localparam int BUSYEN_BIT    = 8;
  localparam int VETOEN_BIT    = 9;
  localparam int EXTEN_BIT     = 0;
  localparam int SWEN_BIT      = 1;
  localparam int AUTOEN_BIT    = 2;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [3:0] MODE_REG    = 4'h0;
  localparam logic [3:0] MODE_TRIG   = 4'h1;
  localparam logic [3:0] MODE_BUSYVT = 4'h2;
  localparam logic [3:0] MODE_LEGACY = 4'h3;

  typedef struct packed {
    logic [31:0] coinc_mask;
    logic [31:0] io_ctrl;
    logic [31:0] group_mode;
    logic [31:0] acq_ctrl;
    logic [31:0] trig_ctrl;
    logic [11:0] af_level;
    logic [15:0] io_wdata;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic        sw_pend;
    logic [7:0]  seen;
    logic [3:0]  win_cnt;
    logic        win_open;
    logic        gtrig;
    logic        trig_out;
    logic [7:0]  ch_trig;
    logic [15:0] lvds_o;
    logic [15:0] lvds_oe;
    logic [15:0] pattern;
    logic        pattern_valid;
    logic        ttt_clear;
    logic        mem_clear;
    logic        busy;
    logic [31:0] rdata;
  } state_t;
endpackage

// ===== hw/trigger_and_front_io_control.sv
// Purpose: board trigger builder and front lvds group control
// Assumes: inputs synchronous to clk except the external trigger
// Notes: register port is the documented internal register access
`timescale 1ns/1ps
`default_nettype none
module trigger_and_front_io_control
  import trig_io_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  // trigger sources
  input  wire logic        ext_trigger,
  input  wire logic [7:0]  channel_local_trigger,
  // board status
  input  wire logic [11:0] buffer_fill,
  input  wire logic        memory_full,
  input  wire logic        data_ready,
  input  wire logic        run_state,
  // trigger results
  output logic             global_trigger,
  output logic             trigger_output_port,
  output logic [7:0]       channel_trigger_outputs,
  output logic [15:0]      event_pattern,
  output logic             event_pattern_valid,
  output logic             time_tag_clear,
  output logic             memory_clear,
  output logic             busy,
  // front lvds lines
  input  wire logic [15:0] lvds_i,
  output logic [15:0]      lvds_o,
  output logic [15:0]      lvds_oe
);
  state_t s;
  state_t next_s;
  logic   sw_hit;
  logic   ext_rise;
  logic [3:0] cnt;
  logic   coinc;
  logic   any_auto;
  logic   veto;
  logic   busy_in;
  logic   fire;
  logic [3:0] gm;
  logic   gdir;

  // ==========================================================
  // next state
  always_comb begin
    next_s   = s;
    sw_hit   = 1'b0;
    cnt      = 4'h0;
    coinc    = 1'b0;
    veto     = 1'b0;
    busy_in  = 1'b0;
    fire     = 1'b0;
    gm       = MODE_REG;
    gdir     = 1'b0;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_COINC_MASK:  next_s.coinc_mask = reg_wdata;
        OFS_IO_CTRL:     next_s.io_ctrl = reg_wdata;
        OFS_GROUP_MODE:  next_s.group_mode = reg_wdata;
        OFS_ACQ_CTRL:    next_s.acq_ctrl = reg_wdata;
        OFS_TRIG_CTRL:   next_s.trig_ctrl = reg_wdata;
        OFS_ALMOST_FULL: next_s.af_level = reg_wdata[11:0];
        OFS_IO_DATA:     next_s.io_wdata = reg_wdata[15:0];
        OFS_SW_TRIGGER:  sw_hit = 1'b1;
        default: ;
      endcase
    end
    // register reads
    if (reg_rd) begin
      case (reg_addr)
        OFS_COINC_MASK:  next_s.rdata = s.coinc_mask;
        OFS_IO_CTRL:     next_s.rdata = s.io_ctrl;
        OFS_GROUP_MODE:  next_s.rdata = s.group_mode;
        OFS_ACQ_CTRL:    next_s.rdata = s.acq_ctrl;
        OFS_TRIG_CTRL:   next_s.rdata = s.trig_ctrl;
        OFS_ALMOST_FULL: next_s.rdata = {20'h00000, s.af_level};
        OFS_IO_DATA:     next_s.rdata = {16'h0000, lvds_i};
        OFS_STATUS:      next_s.rdata = {29'h0, s.busy, s.trig_out, s.gtrig};
        default:         next_s.rdata = RST_ZERO;
      endcase
    end
    // external trigger resync
    next_s.ext_s1   = ext_trigger;
    next_s.ext_s2   = s.ext_s1;
    next_s.ext_prev = s.ext_s2;
    // input group decode
    for (int g = 0; g < 4; g++) begin
      gm   = s.io_ctrl[NEWMODE_BIT] ? s.group_mode[4*g +: 4] : MODE_LEGACY;
      gdir = s.io_ctrl[DIR_LSB + g];
      if (s.io_ctrl[NEWMODE_BIT] && !gdir && gm == MODE_BUSYVT) begin
        veto    = veto | ~lvds_i[4*g+1];
        busy_in = busy_in | ~lvds_i[4*g];
      end
    end
    // coincidence window: channels seen inside window
    if (s.win_open && s.win_cnt != 4'h0) begin
      next_s.seen    = s.seen | (channel_local_trigger & s.coinc_mask[7:0]);
      next_s.win_cnt = s.win_cnt - 4'h1;
    end else if (any_auto) begin
      // expired or idle window: a new trigger opens a fresh one
      next_s.win_open = 1'b1;
      next_s.win_cnt  = s.coinc_mask[WIN_LSB +: 4];
      next_s.seen     = channel_local_trigger & s.coinc_mask[MASK_LSB +: 8];
    end else begin
      next_s.win_open = 1'b0;
      next_s.seen     = 8'h00;
    end
    for (int c = 0; c < 8; c++) begin
      cnt = cnt + {3'b000, next_s.seen[c]};
    end
    if (s.coinc_mask[MAJ_LSB +: 3] == 3'b000) begin
      coinc = any_auto;
    end else begin
      coinc = cnt > {1'b0, s.coinc_mask[MAJ_LSB +: 3]};
      if (coinc) begin
        next_s.win_open = 1'b0;
        next_s.seen     = 8'h00;
      end
    end
    // global trigger build
    fire = (s.trig_ctrl[EXTEN_BIT] & ext_rise)
         | (s.trig_ctrl[SWEN_BIT] & (s.sw_pend | sw_hit))
         | (s.trig_ctrl[AUTOEN_BIT] & coinc);
    if (s.acq_ctrl[VETOEN_BIT] && veto) begin
      fire = 1'b0;
    end
    next_s.sw_pend  = 1'b0;
    next_s.gtrig    = fire;
    next_s.trig_out = fire;
    next_s.ch_trig  = channel_local_trigger;
    next_s.pattern_valid = fire;
    if (fire) begin
      next_s.pattern = lvds_i;
    end
    next_s.busy = (buffer_fill >= s.af_level && s.af_level != 12'h000)
                | (busy_in & s.acq_ctrl[BUSYEN_BIT]);
    next_s.ttt_clear = 1'b0;
    next_s.mem_clear = 1'b0;
    // output groups
    if (!s.io_ctrl[NEWMODE_BIT]) begin
      next_s.lvds_oe = 16'h0FFF;
      next_s.lvds_o  = {4'h0, run_state, s.gtrig, data_ready, memory_full, s.ch_trig};
      next_s.ttt_clear = ~lvds_i[12];
      next_s.mem_clear = ~lvds_i[13];
    end else begin
      for (int g = 0; g < 4; g++) begin
        gm   = s.group_mode[4*g +: 4];
        gdir = s.io_ctrl[DIR_LSB + g];
        next_s.lvds_oe[4*g +: 4] = {4{gdir}};
        case (gm)
          MODE_REG:    next_s.lvds_o[4*g +: 4] = s.io_wdata[4*g +: 4];
          MODE_TRIG:   next_s.lvds_o[4*g +: 4] = g[0] ? s.ch_trig[7:4] : s.ch_trig[3:0];
          MODE_BUSYVT: next_s.lvds_o[4*g +: 4] = {~run_state, ~s.trig_out, ~veto, ~s.busy};
          MODE_LEGACY: next_s.lvds_o[4*g +: 4] = {run_state, s.gtrig, data_ready, s.busy};
          default:     next_s.lvds_o[4*g +: 4] = 4'h0;
        endcase
        if (!gdir && gm == MODE_LEGACY && !lvds_i[4*g]) begin
          next_s.ttt_clear = 1'b1;
        end
      end
    end
    if (sw_hit && !s.trig_ctrl[SWEN_BIT]) begin
      next_s.sw_pend = 1'b0;
    end
  end

  assign ext_rise = s.ext_s2 & ~s.ext_prev;
  assign any_auto = |(channel_local_trigger & s.coinc_mask[7:0]);

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata               = s.rdata;
  assign global_trigger          = s.gtrig;
  assign trigger_output_port     = s.trig_out;
  assign channel_trigger_outputs = s.ch_trig;
  assign event_pattern           = s.pattern;
  assign event_pattern_valid     = s.pattern_valid;
  assign time_tag_clear          = s.ttt_clear;
  assign memory_clear            = s.mem_clear;
  assign busy                    = s.busy;
  assign lvds_o                  = s.lvds_o;
  assign lvds_oe                 = s.lvds_oe;

  // ==========================================================
  // checks
  a_trig_out_copy: assert property (@(posedge clk) disable iff (!resetn)
    trigger_output_port == global_trigger) else $error("trigger out differs");
  a_sw_trigger: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == OFS_SW_TRIGGER && s.trig_ctrl[SWEN_BIT]
    && !(s.acq_ctrl[VETOEN_BIT] && veto) |=> global_trigger) else $error("sw trigger lost");
  a_veto_block: assert property (@(posedge clk) disable iff (!resetn)
    s.acq_ctrl[VETOEN_BIT] && veto |=> !global_trigger) else $error("veto ignored");
  a_ext_sync: assert property (@(posedge clk) disable iff (!resetn)
    s.trig_ctrl[EXTEN_BIT] && !s.acq_ctrl[VETOEN_BIT] && !ext_trigger ##1 ext_trigger
    |-> ##3 global_trigger) else $error("ext trigger not seen");
  a_pattern_latch: assert property (@(posedge clk) disable iff (!resetn)
    fire |=> event_pattern == $past(lvds_i)) else $error("pattern not latched");
  a_legacy_dir: assert property (@(posedge clk) disable iff (!resetn)
    !s.io_ctrl[NEWMODE_BIT] |=> lvds_oe == 16'h0FFF) else $error("legacy dir wrong");
  a_or_mode: assert property (@(posedge clk) disable iff (!resetn)
    s.trig_ctrl[AUTOEN_BIT] && s.coinc_mask[26:24] == 3'b000 && any_auto
    && !(s.acq_ctrl[VETOEN_BIT] && veto) |=> global_trigger) else $error("or mode miss");
  a_majority: assert property (@(posedge clk) disable iff (!resetn)
    s.coinc_mask[MAJ_LSB +: 3] != 3'b000 && coinc
    |-> $countones(s.seen | (channel_local_trigger & s.coinc_mask[7:0]))
        > int'(s.coinc_mask[MAJ_LSB +: 3]))
    else $error("majority wrong");
  a_valid_pulse: assert property (@(posedge clk) disable iff (!resetn)
    event_pattern_valid == global_trigger) else $error("pattern valid differs");

  // ==========================================================
  // coincidence window and channel copy checks
  a_window_hold: assert property (@(posedge clk) disable iff (!resetn)
    s.win_open && s.win_cnt != 4'h0 && !coinc
    |=> s.win_open) else $error("window closed early");
  a_window_close: assert property (@(posedge clk) disable iff (!resetn)
    s.win_open && s.win_cnt == 4'h0 && !any_auto
    |=> !s.win_open) else $error("window overran");
  a_ch_copy: assert property (@(posedge clk) disable iff (!resetn)
    1'b1
    |=> channel_trigger_outputs == $past(channel_local_trigger))
    else $error("channel copy wrong");

  // ==========================================================
  // front io checks
  a_busy_level: assert property (@(posedge clk) disable iff (!resetn)
    s.af_level != 12'h000 && buffer_fill >= s.af_level
    |=> busy) else $error("almost full not busy");
  a_tag_clear: assert property (@(posedge clk) disable iff (!resetn)
    !s.io_ctrl[NEWMODE_BIT] && !lvds_i[12]
    |=> time_tag_clear) else $error("time tag clear missed");
  a_legacy_clear: assert property (@(posedge clk) disable iff (!resetn)
    !s.io_ctrl[NEWMODE_BIT] && !lvds_i[13]
    |=> memory_clear) else $error("memory clear missed");
  a_group_dir: assert property (@(posedge clk) disable iff (!resetn)
    s.io_ctrl[NEWMODE_BIT]
    |=> lvds_oe[15:12] == {4{$past(s.io_ctrl[DIR_LSB + 3])}})
    else $error("group direction wrong");
  a_trig_group: assert property (@(posedge clk) disable iff (!resetn)
    s.io_ctrl[NEWMODE_BIT] && s.group_mode[7:4] == MODE_TRIG
    |=> lvds_o[7:4] == $past(channel_trigger_outputs[7:4]))
    else $error("trigger group wrong");
  a_run_inverse: assert property (@(posedge clk) disable iff (!resetn)
    s.io_ctrl[NEWMODE_BIT] && s.group_mode[3:0] == MODE_BUSYVT
    |=> lvds_o[3] == !$past(run_state)) else $error("run line not inverted");
  a_io_read: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && reg_addr == OFS_IO_DATA
    |=> reg_rdata == {16'h0000, $past(lvds_i)}) else $error("io data read wrong");

  // ==========================================================
  // coverage
  c_sw: cover property (@(posedge clk) reg_wr && reg_addr == OFS_SW_TRIGGER ##1 global_trigger);
  c_maj: cover property (@(posedge clk) s.coinc_mask[26:24] != 3'b000 && coinc);
  c_new: cover property (@(posedge clk) s.io_ctrl[NEWMODE_BIT] && lvds_oe != 16'h0000);
  c_veto: cover property (@(posedge clk) s.acq_ctrl[VETOEN_BIT] && veto && sw_hit);
  c_bv: cover property (@(posedge clk) s.group_mode[3:0] == MODE_BUSYVT && lvds_oe[0]);
endmodule
`default_nettype wire

// ===== tb/far_side.sv
// Purpose: far-side model of trigger source and lvds partners
// Assumes: bench sets line levels and pulse requests
// Notes: line level resolved from design enables
`timescale 1ns/1ps
`default_nettype none
module far_side (
  // design pins
  input  wire logic [15:0] lvds_o,
  input  wire logic [15:0] lvds_oe,
  output logic [15:0]      lvds_i,
  output logic             ext_trigger,
  // bench control
  input  wire logic [15:0] pins,
  input  wire logic        pulse
);
  // ==========================
  // line resolution and unaligned pulse
  assign lvds_i = (lvds_oe & lvds_o) | (~lvds_oe & pins);
  initial ext_trigger = 1'h0;
  always @(posedge pulse) begin
    #7 ext_trigger = 1'h1;
    #53 ext_trigger = 1'h0;
  end
endmodule
`default_nettype wire

// ===== tb/trigger_and_front_io_control_tb_top.sv
// Purpose: self-checking bench for trigger and front io block
// Assumes: 50 MHz clock, inputs driven on falling edge
// Notes: trigger latency checked within short bounds
`timescale 1ns/1ps
`default_nettype none
module trigger_and_front_io_control_tb_top import trig_io_pkg::*;;
  logic        clk, resetn, reg_wr, reg_rd, ext_trigger, pulse;
  logic        memory_full, data_ready, run_state, time_tag_clear, memory_clear;
  logic        global_trigger, trigger_output_port, event_pattern_valid, busy;
  logic [15:0] reg_addr, event_pattern, lvds_i, lvds_o, lvds_oe, pins;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [7:0]  clt, channel_trigger_outputs;
  logic [11:0] buffer_fill;
  int          n_errors, checks, cyc;
  trigger_and_front_io_control u_dut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ext_trigger(ext_trigger), .channel_local_trigger(clt), .buffer_fill(buffer_fill),
    .memory_full(memory_full), .data_ready(data_ready), .run_state(run_state),
    .global_trigger(global_trigger), .trigger_output_port(trigger_output_port),
    .channel_trigger_outputs(channel_trigger_outputs), .event_pattern(event_pattern),
    .event_pattern_valid(event_pattern_valid), .time_tag_clear(time_tag_clear),
    .memory_clear(memory_clear), .busy(busy), .lvds_i(lvds_i), .lvds_o(lvds_o),
    .lvds_oe(lvds_oe));
  far_side u_far (.lvds_o(lvds_o), .lvds_oe(lvds_oe), .lvds_i(lvds_i),
    .ext_trigger(ext_trigger), .pins(pins), .pulse(pulse));
  // ==========================
  // clock and timeout
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
  end
  // ==========================
  // shared tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (e !== s) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] v);
    @(negedge clk);
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask
  task rd(input logic [15:0] a);
    @(negedge clk);
    reg_rd = 1'h1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'h0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task fire(input int n, input logic e, input string nm);
    logic f;
    f = global_trigger;
    for (int i = 0; i < n && f !== 1'h1; i++) begin
      @(negedge clk);
      f = global_trigger;
    end
    chk(nm, e, f);
  endtask
  task pch(input logic [7:0] m, input int gap);
    @(negedge clk);
    clt = m;
    @(negedge clk);
    clt = 8'h00;
    repeat (gap) @(negedge clk);
  endtask
  // ==========================
  // scenarios
  task t_regs;
    rd(OFS_COINC_MASK);
    chk("mask_rst", 32'h0, d);
    rd(OFS_IO_CTRL);
    chk("ioctl_rst", 32'h0, d);
    rd(OFS_GROUP_MODE);
    chk("mode_rst", 32'h0, d);
    rd(16'h8000);
    chk("unmapped", 32'h0, d);
    wr(OFS_COINC_MASK, 32'h0730_00A5);
    rd(OFS_COINC_MASK);
    chk("mask_rw", 32'h0730_00A5, d);
    $display("t_regs done");
  endtask
  task t_sw;
    wr(OFS_TRIG_CTRL, 32'h7);
    pins = 16'hA000;
    wr(OFS_SW_TRIGGER, 32'h0);
    fire(3, 1'h1, "sw_fire");
    chk("trig_out", 1'h1, trigger_output_port);
    chk("pattern", 4'hA, event_pattern[15:12]);
    chk("pat_valid", 1'h1, event_pattern_valid);
    repeat (2) @(negedge clk);
    chk("sw_end", 1'h0, global_trigger);
    pulse = 1'h1;
    fire(6, 1'h1, "ext_fire");
    pulse = 1'h0;
    $display("t_sw done");
  endtask
  task t_coinc;
    wr(OFS_COINC_MASK, 32'h0100_0003);
    pch(8'h01, 0);
    fire(10, 1'h0, "maj_single");
    pch(8'h03, 0);
    fire(6, 1'h1, "maj_pair");
    repeat (8) @(negedge clk);
    pch(8'h01, 2);
    pch(8'h02, 0);
    fire(10, 1'h0, "win0_apart");
    wr(OFS_COINC_MASK, 32'h0130_0003);
    pch(8'h01, 1);
    pch(8'h02, 0);
    fire(8, 1'h1, "win3_pair");
    repeat (8) @(negedge clk);
    wr(OFS_COINC_MASK, 32'h0000_0001);
    pch(8'h02, 0);
    fire(10, 1'h0, "masked_ch");
    pch(8'h01, 0);
    fire(6, 1'h1, "or_ch");
    $display("t_coinc done");
  endtask
  task t_io;
    memory_full = 1'h1;
    data_ready = 1'h1;
    run_state = 1'h1;
    pins = 16'h2000;
    repeat (3) @(negedge clk);
    chk("leg_oe", 16'h0FFF, lvds_oe);
    chk("leg_out", 4'hB, lvds_o[11:8]);
    chk("ttt_clr", 1'h1, time_tag_clear);
    chk("mem_clr", 1'h0, memory_clear);
    wr(OFS_IO_CTRL, 32'h104);
    wr(OFS_IO_DATA, 32'h5);
    pins = 16'h5A30;
    rd(OFS_IO_DATA);
    chk("grp_oe", 16'h000F, lvds_oe);
    chk("reg_out", 4'h5, lvds_o[3:0]);
    chk("reg_in", 12'h5A3, d[15:4]);
    wr(OFS_GROUP_MODE, 32'h3);
    repeat (2) @(negedge clk);
    chk("leg_grp", 4'hA, lvds_o[3:0]);
    wr(OFS_IO_CTRL, 32'h10C);
    wr(OFS_GROUP_MODE, 32'h11);
    clt = 8'h6A;
    repeat (3) @(negedge clk);
    chk("trig_grp", 8'h6A, lvds_o[7:0]);
    chk("ch_trig", 8'h6A, channel_trigger_outputs);
    clt = 8'h00;
    $display("t_io done");
  endtask
  task t_veto;
    wr(OFS_IO_CTRL, 32'h104);
    wr(OFS_GROUP_MODE, 32'h20);
    wr(OFS_ACQ_CTRL, 32'h200);
    pins = 16'h00D0;
    wr(OFS_SW_TRIGGER, 32'h0);
    fire(4, 1'h0, "vetoed");
    pins = 16'h00F0;
    repeat (3) @(negedge clk);
    wr(OFS_SW_TRIGGER, 32'h0);
    fire(3, 1'h1, "unvetoed");
    wr(OFS_ALMOST_FULL, 32'h10);
    buffer_fill = 12'h010;
    repeat (2) @(negedge clk);
    chk("busy_af", 1'h1, busy);
    buffer_fill = 12'h00F;
    wr(OFS_ACQ_CTRL, 32'h100);
    chk("busy_idle", 1'h0, busy);
    pins = 16'h00E0;
    repeat (2) @(negedge clk);
    chk("busy_in", 1'h1, busy);
    wr(OFS_GROUP_MODE, 32'h22);
    repeat (2) @(negedge clk);
    chk("bv_out", 4'h6, lvds_o[3:0]);
    $display("t_veto done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {resetn, reg_wr, reg_rd, pulse, memory_full, data_ready, run_state} = 7'h0;
    {reg_addr, reg_wdata, clt, buffer_fill, pins} = 84'h0;
    repeat (20) @(negedge clk);
    resetn = 1'h1;
    t_regs();
    t_sw();
    t_coinc();
    t_io();
    t_veto();
    results();
  end
endmodule
`default_nettype wire
